//--- src/csr_core.sv
// stack pointer, return stack, prefetch and register file of the cpu core
// What this block does
// - fetch next word while current one executes
// - calls and interrupts push return address automatically
// - small program memory: two bytes, step two
// - large program memory: three bytes, step three
// - returns pop saved address into program counter
// - single push decrements, single pop increments
// - low byte write masks interrupts briefly
// - reset loads pointer with top of SRAM
// - 32 byte registers, single cycle access
// - four read and write port configurations
// - six registers form three data pointers
// - one pointer also addresses flash tables
`timescale 1ns/1ns
`default_nettype none
module csr_core
    import csr_pkg::*;
#(
    parameter int PROG_KB = 128
) (
    input  wire  logic              core_clk,
    input  wire  logic              rstn,
    input  wire  logic              clkEn,
    // program memory fetch port
    input  wire  logic [15:0]       progData,
    input  wire  logic              pcLoad,
    input  wire  logic [PC_W-1:0]   pcTarget,
    output logic [PC_W-1:0]         progAddr,
    output logic [15:0]             instrWord,
    output logic                    instrValid,
    // stack requests and data memory port
    input  wire  csr_stkreq_t       stkReq,
    input  wire  logic [7:0]        dataRdData,
    input  wire  logic              spLowWr,
    input  wire  logic              spHighWr,
    input  wire  logic [7:0]        spWrData,
    input  wire  logic              ioWrite,
    input  wire  logic              instrDone,
    output logic [SP_W-1:0]         dataAddr,
    output logic [7:0]              dataWrData,
    output logic                    dataWrEn,
    output logic                    dataRdEn,
    output logic [SP_W-1:0]         stackPtr,
    output logic [PC_W-1:0]         retPc,
    output logic                    retValid,
    output logic                    popValid,
    output logic [7:0]              popData,
    output logic                    stkBusy,
    output logic                    intMask,
    // register file
    input  wire  csr_rfreq_t        rfReq,
    output logic [15:0]             rfOutA,
    output logic [7:0]              rfOutB,
    output logic [15:0]             ptrX,
    output logic [15:0]             ptrY,
    output logic [15:0]             ptrZ,
    output logic [15:0]             flashTblAddr
);
    localparam logic [1:0] RET_BYTES = (PROG_KB > BIG_PROG_KB) ? RET3_BYTES : RET2_BYTES;

    // ---------------- prefetch ----------------
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [15:0]     iw_reg, iw_next;
    logic            iv_reg, iv_next;

    // fetch next word every cycle; a jump flushes the prefetched word
    always_comb begin
        pc_next = pc_reg + PC_W'(1);
        iw_next = progData;
        iv_next = 1'b1;
        if (pcLoad) begin
            pc_next = pcTarget;
            iv_next = 1'b0;
        end else if (retValid) begin
            pc_next = retPc;
            iv_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pc_reg <= '0;
            iw_reg <= '0;
            iv_reg <= 1'b0;
        end else if (clkEn) begin
            pc_reg <= pc_next;
            iw_reg <= iw_next;
            iv_reg <= iv_next;
        end
    end

    // ---------------- stack ----------------
    csr_stk_t        st_reg, st_next;
    logic [SP_W-1:0] sp_reg, sp_next;
    logic [1:0]      cnt_reg, cnt_next;
    logic [PC_W-1:0] ra_reg, ra_next;
    logic [SP_W-1:0] da_reg, da_next;
    logic [7:0]      dw_reg, dw_next;
    logic            dwe_reg, dwe_next;
    logic            dre_reg, dre_next;
    logic            rv_reg, rv_next;
    logic            pv_reg, pv_next;
    logic [7:0]      pd_reg, pd_next;
    logic            ret_reg, ret_next;      // multi-byte pop is a return
    logic            rdp_reg, rdp_next;      // read issued last cycle
    logic [2:0]      mk_reg, mk_next;
    logic            bsy_reg, bsy_next;      // multi-byte transfer in progress
    logic            im_reg, im_next;        // interrupts held off

    // push and pop sequencer; return bytes go low byte at highest address
    always_comb begin
        st_next  = st_reg;
        sp_next  = sp_reg;
        cnt_next = cnt_reg;
        ra_next  = ra_reg;
        da_next  = da_reg;
        dw_next  = dw_reg;
        dwe_next = 1'b0;
        dre_next = 1'b0;
        rv_next  = 1'b0;
        pv_next  = 1'b0;
        pd_next  = pd_reg;
        ret_next = ret_reg;
        rdp_next = dre_reg;
        // collect popped byte one cycle after the read
        if (rdp_reg) begin
            if (ret_reg) begin
                ra_next = {ra_reg[PC_W-9:0], dataRdData};
                // complete only on the last byte: no further read in flight
                if (st_reg == CSR_IDLE && !dre_reg) begin
                    rv_next = 1'b1;
                end
            end else begin
                pd_next = dataRdData;
                pv_next = 1'b1;
            end
        end
        unique case (st_reg)
            CSR_IDLE: begin
                if (spLowWr) begin
                    sp_next = {sp_reg[SP_W-1:8], spWrData};
                end else if (spHighWr) begin
                    sp_next = {spWrData, sp_reg[7:0]};
                end else if (stkReq.call) begin
                    ra_next  = stkReq.retAddr;
                    cnt_next = RET_BYTES;
                    st_next  = CSR_PUSH;
                end else if (stkReq.ret) begin
                    cnt_next = RET_BYTES;
                    ret_next = 1'b1;
                    ra_next  = '0;
                    st_next  = CSR_POP;
                end else if (stkReq.push) begin
                    da_next  = sp_reg;
                    dw_next  = stkReq.pushData;
                    dwe_next = 1'b1;
                    sp_next  = sp_reg - SP_ONE;
                end else if (stkReq.pop && !rdp_reg) begin
                    sp_next  = sp_reg + SP_ONE;
                    da_next  = sp_reg + SP_ONE;
                    dre_next = 1'b1;
                    ret_next = 1'b0;
                end
            end
            CSR_PUSH: begin
                // low byte first, each at current pointer then decrement
                da_next  = sp_reg;
                dw_next  = ra_reg[7:0];
                ra_next  = {8'h00, ra_reg[PC_W-1:8]};
                dwe_next = 1'b1;
                sp_next  = sp_reg - SP_ONE;
                cnt_next = cnt_reg - 2'h1;
                if (cnt_reg == 2'h1) begin
                    st_next = CSR_IDLE;
                end
            end
            CSR_POP: begin
                // high byte comes back first, increment before reading
                sp_next  = sp_reg + SP_ONE;
                da_next  = sp_reg + SP_ONE;
                dre_next = 1'b1;
                cnt_next = cnt_reg - 2'h1;
                if (cnt_reg == 2'h1) begin
                    st_next = CSR_IDLE;
                end
            end
            default: st_next = CSR_IDLE;
        endcase
        // interrupt mask after pointer low byte write
        mk_next = mk_reg;
        if (spLowWr) begin
            mk_next = MASK_HOLD;
        end else if (ioWrite) begin
            mk_next = 3'h0;
        end else if (instrDone && mk_reg != 3'h0) begin
            mk_next = mk_reg - 3'h1;
        end
        // status outputs registered from their next state
        bsy_next = (st_next != CSR_IDLE);
        im_next  = (mk_next != 3'h0);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg  <= CSR_IDLE;
            sp_reg  <= SRAM_TOP;
            cnt_reg <= '0;
            ra_reg  <= '0;
            da_reg  <= '0;
            dw_reg  <= '0;
            dwe_reg <= 1'b0;
            dre_reg <= 1'b0;
            rv_reg  <= 1'b0;
            pv_reg  <= 1'b0;
            pd_reg  <= '0;
            ret_reg <= 1'b0;
            rdp_reg <= 1'b0;
            mk_reg  <= '0;
            bsy_reg <= 1'b0;
            im_reg  <= 1'b0;
        end else if (clkEn) begin
            st_reg  <= st_next;
            sp_reg  <= sp_next;
            cnt_reg <= cnt_next;
            ra_reg  <= ra_next;
            da_reg  <= da_next;
            dw_reg  <= dw_next;
            dwe_reg <= dwe_next;
            dre_reg <= dre_next;
            rv_reg  <= rv_next;
            pv_reg  <= pv_next;
            pd_reg  <= pd_next;
            ret_reg <= ret_next;
            rdp_reg <= rdp_next;
            mk_reg  <= mk_next;
            bsy_reg <= bsy_next;
            im_reg  <= im_next;
        end
    end

    // ---------------- register file ----------------
    logic [7:0]  rf_reg   [RF_DEPTH];
    logic [7:0]  rf_next  [RF_DEPTH];
    logic [15:0] oa_reg, oa_next;
    logic [7:0]  ob_reg, ob_next;
    logic [RF_AW-1:0] pairHi;

    // write one byte or an aligned pair, read per configuration
    always_comb begin
        pairHi = {rfReq.wrAddr[RF_AW-1:1], 1'b1};
        for (int i = 0; i < RF_DEPTH; i++) begin
            rf_next[i] = rf_reg[i];
        end
        if (rfReq.wrEn) begin
            rf_next[rfReq.wrAddr] = rfReq.wrData[7:0];
            if (rfReq.mode == CSR_R88_W16 || rfReq.mode == CSR_R16_W16) begin
                rf_next[pairHi] = rfReq.wrData[15:8];
            end
        end
        unique case (rfReq.mode)
            CSR_R8_W8: begin
                oa_next = {8'h00, rf_reg[rfReq.rdA]};
                ob_next = 8'h00;
            end
            CSR_R88_W8, CSR_R88_W16: begin
                oa_next = {8'h00, rf_reg[rfReq.rdA]};
                ob_next = rf_reg[rfReq.rdB];
            end
            CSR_R16_W16: begin
                oa_next = {rf_reg[{rfReq.rdA[RF_AW-1:1], 1'b1}],
                           rf_reg[{rfReq.rdA[RF_AW-1:1], 1'b0}]};
                ob_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < RF_DEPTH; i++) begin
                rf_reg[i] <= 8'h00;
            end
            oa_reg <= '0;
            ob_reg <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < RF_DEPTH; i++) begin
                rf_reg[i] <= rf_next[i];
            end
            oa_reg <= oa_next;
            ob_reg <= ob_next;
        end
    end

    // outputs straight from flip-flops
    assign progAddr     = pc_reg;
    assign instrWord    = iw_reg;
    assign instrValid   = iv_reg;
    assign dataAddr     = da_reg;
    assign dataWrData   = dw_reg;
    assign dataWrEn     = dwe_reg;
    assign dataRdEn     = dre_reg;
    assign stackPtr     = sp_reg;
    assign retPc        = ra_reg;
    assign retValid     = rv_reg;
    assign popValid     = pv_reg;
    assign popData      = pd_reg;
    assign stkBusy      = bsy_reg;
    assign intMask      = im_reg;
    assign rfOutA       = oa_reg;
    assign rfOutB       = ob_reg;
    assign ptrX         = {rf_reg[PTR_X_LO + 5'h1], rf_reg[PTR_X_LO]};
    assign ptrY         = {rf_reg[PTR_Y_LO + 5'h1], rf_reg[PTR_Y_LO]};
    assign ptrZ         = {rf_reg[PTR_Z_LO + 5'h1], rf_reg[PTR_Z_LO]};
    assign flashTblAddr = {rf_reg[PTR_Z_LO + 5'h1], rf_reg[PTR_Z_LO]};
endmodule // csr_core
`default_nettype wire

//--- src/csr_pkg.sv
// package for the cpu stack, prefetch and register file block
package csr_pkg;
    localparam int          PC_W        = 22;          // program counter width (words)
    localparam int          SP_W        = 16;          // stack pointer width
    localparam int          RF_DEPTH    = 32;          // working registers
    localparam int          RF_AW       = 5;
    localparam logic [SP_W-1:0] SRAM_TOP = 16'h3FFF;   // highest on-chip data address
    localparam int          BIG_PROG_KB = 128;         // threshold for 3-byte returns
    localparam logic [2:0]  MASK_HOLD   = 3'h4;        // instructions masked after low write
    localparam logic [4:0]  PTR_X_LO    = 5'h1A;       // first of three pointer pairs
    localparam logic [4:0]  PTR_Y_LO    = 5'h1C;
    localparam logic [4:0]  PTR_Z_LO    = 5'h1E;
    localparam logic [1:0]  RET2_BYTES  = 2'h2;
    localparam logic [1:0]  RET3_BYTES  = 2'h3;
    localparam logic [SP_W-1:0] SP_ONE  = 16'h0001;

    // register file port configuration
    typedef enum logic [1:0] {
        CSR_R8_W8   = 2'b00,
        CSR_R88_W8  = 2'b01,
        CSR_R88_W16 = 2'b10,
        CSR_R16_W16 = 2'b11
    } csr_rfmode_t;

    // stack sequencer states
    typedef enum logic [1:0] {
        CSR_IDLE = 2'b00,
        CSR_PUSH = 2'b01,
        CSR_POP  = 2'b10
    } csr_stk_t;

    // register file request
    typedef struct packed {
        csr_rfmode_t      mode;
        logic [RF_AW-1:0] rdA;
        logic [RF_AW-1:0] rdB;
        logic             wrEn;
        logic [RF_AW-1:0] wrAddr;
        logic [15:0]      wrData;
    } csr_rfreq_t;

    // stack request from the decoder
    typedef struct packed {
        logic            call;       // call or interrupt entry
        logic            ret;        // either return instruction
        logic            push;
        logic            pop;
        logic [7:0]      pushData;
        logic [PC_W-1:0] retAddr;
    } csr_stkreq_t;
endpackage

//--- test/csr_core_assertions.sv
// assertion checker for the stack, fetch and register file core
`timescale 1ns/1ns
`default_nettype none
module csr_core_assertions
    import csr_pkg::*;
#(
    parameter int PROG_KB = 128
) (
    input wire logic            core_clk,
    input wire logic            rstn,
    input wire logic            clkEn,
    input wire logic            pcLoad,
    input wire logic [PC_W-1:0] pcTarget,
    input wire logic [PC_W-1:0] progAddr,
    input wire csr_stkreq_t     stkReq,
    input wire logic            spLowWr,
    input wire logic            spHighWr,
    input wire logic            ioWrite,
    input wire logic            instrDone,
    input wire logic [SP_W-1:0] dataAddr,
    input wire logic [7:0]      dataWrData,
    input wire logic            dataWrEn,
    input wire logic            dataRdEn,
    input wire logic [SP_W-1:0] stackPtr,
    input wire logic            retValid,
    input wire logic            popValid,
    input wire logic            stkBusy,
    input wire logic            intMask,
    input wire logic [15:0]     ptrZ,
    input wire logic [15:0]     flashTblAddr
);
    localparam int RMIN = (PROG_KB > BIG_PROG_KB) ? 4 : 3;
    localparam int RMAX = RMIN + 2;
    logic       idle;
    logic [2:0] doneCnt_reg;
    logic [2:0] doneCnt_next;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // stack request taken with no pointer write competing
    assign idle = clkEn && !stkBusy && !spLowWr && !spHighWr;
    // completed instructions since the last low byte write, saturating
    always_comb begin
        doneCnt_next = doneCnt_reg;
        if (clkEn && spLowWr) begin
            doneCnt_next = 3'h0;
        end else if (clkEn && instrDone && doneCnt_reg != 3'h7) begin
            doneCnt_next = doneCnt_reg + 3'h1;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            doneCnt_reg <= 3'h7;
        end else begin
            doneCnt_reg <= doneCnt_next;
        end
    end
    a_push_write: assert property (
        idle && stkReq.push && !stkReq.call && !stkReq.ret |=> dataWrEn
        && dataAddr == $past(stackPtr) && dataWrData == $past(stkReq.pushData))
        else $error("push byte not written at the stack pointer");
    a_pop_read: assert property (
        idle && stkReq.pop && !stkReq.push && !stkReq.call && !stkReq.ret
        |=> dataRdEn && dataAddr == $past(stackPtr) + SP_ONE ##2 popValid)
        else $error("pop did not read above the stack pointer");
    a_call_save: assert property (
        idle && stkReq.call |=> stkBusy ##1 dataWrEn && dataAddr == $past(stackPtr, 2)
        && dataWrData == $past(stkReq.retAddr[7:0], 2))
        else $error("call did not save its low address byte");
    a_ret_done: assert property (
        idle && stkReq.ret && !stkReq.call |-> ##[RMIN:RMAX] retValid)
        else $error("return address not restored in time");
    a_mask_set: assert property (
        clkEn && spLowWr && !stkBusy |=> intMask)
        else $error("low byte write did not mask interrupts");
    a_mask_io: assert property (
        clkEn && intMask && ioWrite && !spLowWr |=> !intMask)
        else $error("io write did not end the mask");
    a_mask_four: assert property (
        doneCnt_reg == 3'h4 |-> !intMask)
        else $error("mask outlasted four instructions");
    a_flash_ptr: assert property (
        flashTblAddr == ptrZ)
        else $error("flash table pointer differs from third pair");
    a_fetch_load: assert property (
        clkEn && pcLoad |=> progAddr == $past(pcTarget))
        else $error("fetch address not loaded");
    c_call: cover property (idle && stkReq.call);
    c_ret: cover property (retValid);
    c_pop: cover property (popValid);
    c_io_clear: cover property (intMask && ioWrite);
endmodule // csr_core_assertions
bind csr_core csr_core_assertions #(.PROG_KB(PROG_KB)) u_chk (
    .core_clk, .rstn, .clkEn, .pcLoad, .pcTarget, .progAddr, .stkReq, .spLowWr,
    .spHighWr, .ioWrite, .instrDone, .dataAddr, .dataWrData, .dataWrEn, .dataRdEn,
    .stackPtr, .retValid, .popValid, .stkBusy, .intMask, .ptrZ, .flashTblAddr
);
`default_nettype wire

//--- test/csr_mem_model.sv
// program and data memory seen from the far side of the core
`timescale 1ns/1ns
`default_nettype none
module csr_mem_model
    import csr_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic [PC_W-1:0] progAddr,
    input  wire logic [SP_W-1:0] dataAddr,
    input  wire logic [7:0]      dataWrData,
    input  wire logic            dataWrEn,
    input  wire logic            dataRdEn,
    output logic      [15:0]     progData,
    output logic      [7:0]      dataRdData
);
    logic [7:0] mem [0:16383];
    // program word is a fixed pattern of its address, answered at once
    assign progData = progAddr[15:0] ^ 16'hC3A5;
    // read data stands one cycle, then shows its inverse
    always @(posedge core_clk) begin
        if (dataWrEn) begin
            mem[dataAddr[13:0]] <= dataWrData;
        end
        dataRdData <= dataRdEn ? mem[dataAddr[13:0]] : ~dataRdData;
    end
endmodule // csr_mem_model
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the stack, fetch and register file core
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import csr_pkg::*;
    logic            core_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, pcLoad = 1'b0;
    logic            spLowWr = 1'b0, spHighWr = 1'b0, ioWrite = 1'b0, instrDone = 1'b0;
    logic [PC_W-1:0] pcTarget = '0, progAddr, retPc, bProgAddr, bRetPc;
    logic [7:0]      spWrData = 8'h00, dataWrData, dataRdData, popData, rfOutB;
    logic [7:0]      bDataWrData, bDataRdData;
    logic [15:0]     progData, instrWord, rfOutA, ptrX, ptrY, ptrZ, flashTblAddr, bProgData;
    logic [SP_W-1:0] dataAddr, stackPtr, bDataAddr, bStackPtr;
    logic            instrValid, dataWrEn, dataRdEn, retValid, popValid, stkBusy, intMask;
    logic            bDataWrEn, bDataRdEn, bRetValid, bStkBusy;
    csr_stkreq_t     stkReq = '0;
    csr_rfreq_t      rfReq = '0;
    int              errCount = 0, samplesChecked = 0;
    // two-byte and three-byte return cores side by side
    csr_core u_dut (.core_clk, .rstn, .clkEn, .progData, .pcLoad, .pcTarget, .progAddr,
        .instrWord, .instrValid, .stkReq, .dataRdData, .spLowWr, .spHighWr, .spWrData,
        .ioWrite, .instrDone, .dataAddr, .dataWrData, .dataWrEn, .dataRdEn, .stackPtr,
        .retPc, .retValid, .popValid, .popData, .stkBusy, .intMask, .rfReq, .rfOutA,
        .rfOutB, .ptrX, .ptrY, .ptrZ, .flashTblAddr);
    csr_core #(.PROG_KB(256)) u_big (.core_clk, .rstn, .clkEn, .progData(bProgData),
        .pcLoad, .pcTarget, .progAddr(bProgAddr), .instrWord(), .instrValid(), .stkReq,
        .dataRdData(bDataRdData), .spLowWr, .spHighWr, .spWrData, .ioWrite, .instrDone,
        .dataAddr(bDataAddr), .dataWrData(bDataWrData), .dataWrEn(bDataWrEn),
        .dataRdEn(bDataRdEn), .stackPtr(bStackPtr), .retPc(bRetPc), .retValid(bRetValid),
        .popValid(), .popData(), .stkBusy(bStkBusy), .intMask(), .rfReq, .rfOutA(),
        .rfOutB(), .ptrX(), .ptrY(), .ptrZ(), .flashTblAddr());
    csr_mem_model u_mem (.core_clk, .progAddr, .dataAddr, .dataWrData, .dataWrEn,
        .dataRdEn, .progData, .dataRdData);
    csr_mem_model u_memB (.core_clk, .progAddr(bProgAddr), .dataAddr(bDataAddr),
        .dataWrData(bDataWrData), .dataWrEn(bDataWrEn), .dataRdEn(bDataRdEn),
        .progData(bProgData), .dataRdData(bDataRdData));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic testFetch;
        @(posedge core_clk);
        pcLoad <= 1'b1;
        pcTarget <= 22'h000100;
        @(posedge core_clk);
        pcLoad <= 1'b0;
        #1;
        chk(progAddr, 22'h000100);
        edges(1);
        chk(progAddr, 22'h000101);
        chk(instrWord, 16'hC2A5);
        edges(1);
        chk(instrWord, 16'hC2A4);
        chk(instrValid, 1'b1);
        // clock enable low freezes the fetch address
        @(posedge core_clk);
        clkEn <= 1'b0;
        edges(2);
        chk(progAddr, 22'h000103);
        @(posedge core_clk);
        clkEn <= 1'b1;
    endtask
    task automatic testCall;
        int i;
        logic gotA, gotB;
        gotA = 1'b0;
        gotB = 1'b0;
        @(posedge core_clk);
        stkReq.call <= 1'b1;
        stkReq.retAddr <= 22'h2A1234;
        @(posedge core_clk);
        stkReq.call <= 1'b0;
        #1;
        for (i = 0; i < 20 && (stkBusy !== 1'b0 || bStkBusy !== 1'b0); i++) edges(1);
        if (i == 20) begin
            errCount++;
            completeRun();
        end
        // let the last byte land in memory
        edges(1);
        chk(stackPtr, SRAM_TOP - 16'h0002);
        chk(bStackPtr, SRAM_TOP - 16'h0003);
        chk(u_mem.mem[14'h3FFF], 8'h34);
        chk(u_mem.mem[14'h3FFE], 8'h12);
        chk(u_memB.mem[14'h3FFD], 8'h2A);
        @(posedge core_clk);
        stkReq.ret <= 1'b1;
        @(posedge core_clk);
        stkReq.ret <= 1'b0;
        for (i = 0; i < 20 && !(gotA && gotB); i++) begin
            edges(1);
            gotA |= (retValid === 1'b1);
            gotB |= (bRetValid === 1'b1);
        end
        if (!(gotA && gotB)) begin
            errCount++;
            completeRun();
        end
        edges(1);
        chk(retPc, 22'h001234);
        chk(bRetPc, 22'h2A1234);
        chk(stackPtr, SRAM_TOP);
        chk(bStackPtr, SRAM_TOP);
    endtask
    task automatic popOne(input logic [7:0] exp);
        int i;
        @(posedge core_clk);
        stkReq.pop <= 1'b1;
        @(posedge core_clk);
        stkReq.pop <= 1'b0;
        #1;
        for (i = 0; i < 5 && popValid !== 1'b1; i++) edges(1);
        if (i == 5) begin
            errCount++;
            completeRun();
        end
        chk(popData, exp);
    endtask
    task automatic testPushPop;
        @(posedge core_clk);
        stkReq.push <= 1'b1;
        stkReq.pushData <= 8'hA1;
        @(posedge core_clk);
        stkReq.pushData <= 8'hB2;
        @(posedge core_clk);
        stkReq.push <= 1'b0;
        edges(1);
        chk(stackPtr, SRAM_TOP - 16'h0002);
        popOne(8'hB2);
        popOne(8'hA1);
        edges(1);
        chk(stackPtr, SRAM_TOP);
    endtask
    task automatic testMask;
        @(posedge core_clk);
        spLowWr <= 1'b1;
        spWrData <= SRAM_TOP[7:0];
        @(posedge core_clk);
        spLowWr <= 1'b0;
        #1;
        repeat (4) begin
            chk(intMask, 1'b1);
            @(posedge core_clk);
            instrDone <= 1'b1;
            @(posedge core_clk);
            instrDone <= 1'b0;
            #1;
        end
        chk(intMask, 1'b0);
        @(posedge core_clk);
        spHighWr <= 1'b1;
        spWrData <= SRAM_TOP[15:8];
        @(posedge core_clk);
        spHighWr <= 1'b0;
        spLowWr <= 1'b1;
        spWrData <= SRAM_TOP[7:0];
        @(posedge core_clk);
        spLowWr <= 1'b0;
        ioWrite <= 1'b1;
        @(posedge core_clk);
        ioWrite <= 1'b0;
        #1;
        chk(intMask, 1'b0);
        chk(stackPtr, SRAM_TOP);
    endtask
    task automatic rf(input csr_rfmode_t m, input logic [4:0] a, input logic [4:0] b,
        input logic we, input logic [4:0] wa, input logic [15:0] wd);
        @(posedge core_clk);
        rfReq <= '{m, a, b, we, wa, wd};
        @(posedge core_clk);
        rfReq <= '0;
        #1;
    endtask
    task automatic testRegs;
        rf(CSR_R8_W8, 5'h00, 5'h00, 1'b1, 5'h03, 16'h0011);
        rf(CSR_R8_W8, 5'h03, 5'h00, 1'b0, 5'h00, 16'h0000);
        chk(rfOutA[7:0], 8'h11);
        rf(CSR_R88_W8, 5'h03, 5'h03, 1'b1, 5'h1F, 16'h0022);
        chk({rfOutA[7:0], rfOutB}, 16'h1111);
        rf(CSR_R88_W16, 5'h1F, 5'h03, 1'b1, 5'h06, 16'h4433);
        chk({rfOutA[7:0], rfOutB}, 16'h2211);
        rf(CSR_R16_W16, 5'h06, 5'h00, 1'b1, 5'h1A, 16'hBEEF);
        chk(rfOutA, 16'h4433);
        rf(CSR_R88_W8, 5'h07, 5'h06, 1'b1, 5'h1C, 16'h0012);
        chk({rfOutA[7:0], rfOutB}, 16'h4433);
        rf(CSR_R8_W8, 5'h00, 5'h00, 1'b1, 5'h1D, 16'h0034);
        rf(CSR_R88_W16, 5'h00, 5'h00, 1'b1, 5'h1E, 16'h5678);
        chk(ptrX, 16'hBEEF);
        chk(ptrY, 16'h3412);
        chk(ptrZ, 16'h5678);
        chk(flashTblAddr, 16'h5678);
    endtask
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        chk(stackPtr, SRAM_TOP);
        chk(bStackPtr, SRAM_TOP);
        rstn <= 1'b1;
        testFetch();
        testCall();
        testPushPop();
        testMask();
        testRegs();
        completeRun();
    end
endmodule // testbench
`default_nettype wire
